//--- bcs_boot_select.sv
// bcs_boot_select.sv - boot chip-select: reset configuration, address decode and timing
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.svh"

module bcs_boot_select #(
  parameter int ADDR_W = 24,
  parameter int WAIT_W = 4
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  // bus cycle from the internal master
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [2:0]        fc_i,
  input  wire logic              rd_wr_b_i,         // 1 read, 0 write
  input  wire logic [1:0]        siz_i,
  input  wire logic              addr_strobe_b_i,
  input  wire logic              data_strb_b_i,
  input  wire logic              eclk_en_i,         // synchronous-mode enable pulse
  // reset strap
  input  wire logic              data_line_zero_i,
  // configuration write
  input  wire logic              cfg_wr_i,
  input  wire logic [1:0]        cfg_pin_i,
  input  wire logic [12:0]       cfg_base_i,
  input  wire logic [2:0]        cfg_blk_i,
  input  wire logic              cfg_sync_i,
  input  wire logic [1:0]        cfg_byte_i,
  input  wire logic [1:0]        cfg_rw_i,
  input  wire logic              cfg_strb_i,
  input  wire logic [WAIT_W-1:0] cfg_ack_i,
  input  wire logic [1:0]        cfg_space_i,
  input  wire logic [2:0]        cfg_ipl_i,
  input  wire logic              cfg_avec_i,
  // external side
  output logic                   boot_rom_select_b_o,
  output logic [1:0]             transfer_size_ack_b_o,
  output logic                   autovec_b_o,
  // status
  output logic [1:0]             pin_assign_o,
  output logic                   port16_o,
  output logic [12:0]            base_o,
  output logic [2:0]             blk_o
);

  generate
    if (ADDR_W != 24) begin : g_chk
      $error("bcs_boot_select: address comparison is built for 24 address bits");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  logic [1:0]           pin_q;        // select_pin_assign_reg0 boot field
  logic                 strap_done_q; // port size already caught
  logic [12:0]          base_q;       // boot_base_reg base field
  bcs_pkg::bcs_blk_t    blk_q;        // boot_base_reg block size
  logic                 sync_q;       // boot_option_reg mode, 1 = synchronous
  bcs_pkg::bcs_byte_t   byte_q;       // byte lane
  bcs_pkg::bcs_rw_t     rw_q;         // direction
  logic                 strb_q;       // 1 = time with data strobe
  logic [WAIT_W-1:0]    ack_q;        // acknowledge field
  bcs_pkg::bcs_space_t  space_q;      // address space
  logic [2:0]           ipl_q;        // irq_level_match field
  logic                 avec_q;       // internal autovector
  // cycle state
  logic                 sel_q;        // select asserted
  logic                 avec_hit_q;   // autovector pending
  logic [1:0]           ack_b;        // from the wait counter
  logic                 cycle_on;     // address strobe active
  logic                 hit;          // all comparisons pass
  logic                 trig;         // assertion moment

  ////////////////////////////////////////////////////////////////////////////
  // block size to compare mask over address bits [23:11]
  function automatic logic [12:0] size_mask(input bcs_pkg::bcs_blk_t blk);
    logic [12:0] m;
    m = 13'h1FFF;
    unique case (blk)
      bcs_pkg::BCS_BLK_2K:   m = 13'h1FFF;
      bcs_pkg::BCS_BLK_8K:   m = 13'h1FFC;
      bcs_pkg::BCS_BLK_16K:  m = 13'h1FF8;
      bcs_pkg::BCS_BLK_64K:  m = 13'h1FE0;
      bcs_pkg::BCS_BLK_128K: m = 13'h1FC0;
      bcs_pkg::BCS_BLK_256K: m = 13'h1F80;
      bcs_pkg::BCS_BLK_512K: m = 13'h1F00;
      bcs_pkg::BCS_BLK_1M:   m = 13'h1E00;
    endcase
    return m;
  endfunction

  // function code against the space field
  function automatic logic space_ok(input bcs_pkg::bcs_space_t sp, input logic [2:0] fc);
    logic usr;
    logic sup;
    usr = (fc == 3'h1) || (fc == 3'h2);
    sup = (fc == 3'h5) || (fc == 3'h6);
    unique case (sp)
      bcs_pkg::BCS_SP_CPU:    space_ok = (fc == `BCS_FC_CPU);
      bcs_pkg::BCS_SP_USER:   space_ok = usr;
      bcs_pkg::BCS_SP_SUPER:  space_ok = sup;
      bcs_pkg::BCS_SP_SUPUSR: space_ok = usr || sup;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin assignment: upper bit resets to one, lower bit caught at release
  // the strap flop resets to the pulled-up default and takes the line on the
  // first edge after release, so a flop never loads a port under reset
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_q        <= {`BCS_RST_PIN_MSB, `BCS_RST_PIN_LSB};
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      pin_q[0]     <= data_line_zero_i;
      strap_done_q <= 1'b1;
    end else if (cfg_wr_i) begin
      pin_q <= cfg_pin_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // base register: boot rom mapped at the vector table
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      base_q <= `BCS_RST_BASE;
      blk_q  <= `BCS_RST_BLK;
    end else if (cfg_wr_i) begin
      base_q <= cfg_base_i;
      blk_q  <= bcs_pkg::bcs_blk_t'(cfg_blk_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option register: usable before software touches it
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byte_q  <= `BCS_RST_BYTE;
      sync_q  <= `BCS_RST_SYNC;
      rw_q    <= `BCS_RST_RW;
      strb_q  <= `BCS_RST_STRB;
      ack_q   <= WAIT_W'(`BCS_RST_ACK);
      space_q <= `BCS_RST_SPACE;
      ipl_q   <= `BCS_RST_IPL;
      avec_q  <= `BCS_RST_AVEC;
    end else if (cfg_wr_i) begin
      byte_q  <= bcs_pkg::bcs_byte_t'(cfg_byte_i);
      sync_q  <= cfg_sync_i;
      rw_q    <= bcs_pkg::bcs_rw_t'(cfg_rw_i);
      strb_q  <= cfg_strb_i;
      ack_q   <= cfg_ack_i;
      space_q <= bcs_pkg::bcs_space_t'(cfg_space_i);
      ipl_q   <= cfg_ipl_i;
      avec_q  <= cfg_avec_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address and cycle type comparison
  // all fields must match
  always_comb begin
    logic addr_ok;
    logic rw_ok;
    logic lane_ok;
    logic ipl_ok;
    logic upper;
    logic lower;
    // lane closed unless the byte field opens it
    lane_ok = 1'b0;
    addr_ok = ((addr_i[ADDR_W-1:`BCS_BASE_LSB] ^ base_q) & size_mask(blk_q)) == 13'h0000;
    rw_ok   = rd_wr_b_i ? rw_q[0] : rw_q[1];
    upper   = !addr_i[0];
    lower   = addr_i[0] || (siz_i != `BCS_SIZ_BYTE);
    // an 8-bit port ignores the lane, but a disabled field still blocks
    unique case (byte_q)
      bcs_pkg::BCS_BYTE_OFF:   lane_ok = 1'b0;
      bcs_pkg::BCS_BYTE_LOWER: lane_ok = !pin_q[0] || lower;
      bcs_pkg::BCS_BYTE_UPPER: lane_ok = !pin_q[0] || upper;
      bcs_pkg::BCS_BYTE_BOTH:  lane_ok = 1'b1;
    endcase
    // interrupt level only counts in cpu space; zero means any level
    ipl_ok = (fc_i != `BCS_FC_CPU) || (ipl_q == 3'h0) || (addr_i[3:1] == ipl_q);
    hit = pin_q[1] && addr_ok && rw_ok && lane_ok && ipl_ok && space_ok(space_q, fc_i);
  end

  // assertion moment: strobe in asynchronous mode, clock enable in synchronous
  assign cycle_on = !addr_strobe_b_i;
  assign trig     = sync_q ? eclk_en_i : (!strb_q || !data_strb_b_i);

  ////////////////////////////////////////////////////////////////////////////
  // select output: set on match, held to the end of the bus cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_q <= 1'b0;
    end else if (!cycle_on) begin
      sel_q <= 1'b0;
    end else if (!sel_q && hit && trig) begin
      sel_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal acknowledge only in asynchronous mode
  // ack field drives counter
  bcs_wait_ack #(
    .WAIT_W (WAIT_W)
  ) u_wait_ack (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .select_i   (sel_q && !sync_q),
    .cycle_on_i (cycle_on),
    .ack_code_i (ack_q),
    .port16_i   (pin_q[0]),
    .ack_b_o    (ack_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // autovector: cpu space cycle with the internal vector chosen
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avec_hit_q <= 1'b0;
    end else if (!cycle_on) begin
      avec_hit_q <= 1'b0;
    end else if (sel_q && avec_q && (fc_i == `BCS_FC_CPU)) begin
      avec_hit_q <= 1'b1;
    end
  end

  // autovector replaces the size acknowledge
  assign transfer_size_ack_b_o = avec_hit_q ? 2'h3 : ack_b;
  assign autovec_b_o           = !avec_hit_q;
  assign boot_rom_select_b_o   = !sel_q;
  assign pin_assign_o          = pin_q;
  assign port16_o              = pin_q[0];
  assign base_o                = base_q;
  assign blk_o                 = blk_q;

endmodule
`default_nettype wire

//--- bcs_boot_select_chk.sv
// bcs_boot_select_chk.sv - port assertions of the boot chip-select
`timescale 1ns/1ps
`default_nettype none

module bcs_boot_select_chk #(
  parameter int ADDR_W = 24
) (
  // clock and reset
  input wire logic              core_clk_i,
  input wire logic              rst_b_i,
  // watched inputs
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic              addr_strobe_b_i,
  input wire logic              cfg_wr_i,
  // watched outputs
  input wire logic              boot_rom_select_b_o,
  input wire logic [1:0]        transfer_size_ack_b_o,
  input wire logic [1:0]        pin_assign_o,
  input wire logic              port16_o,
  input wire logic [12:0]       base_o,
  input wire logic [2:0]        blk_o
);
  // high once software rewrote the fields: reset defaults no longer hold
  logic cfg_seen_q;

  //////////////////////////////////////////////////////////////////////////////
  // track whether reset defaults are still in force
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_seen_q <= 1'b0;
    end else if (cfg_wr_i) begin
      cfg_seen_q <= 1'b1;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  //////////////////////////////////////////////////////////////////////////////
  a_sel_needs_strobe:
    assert property ($fell(boot_rom_select_b_o) |-> !$past(addr_strobe_b_i))
    else $error("select asserted without address strobe");
  a_sel_cycle_end:
    assert property ($rose(addr_strobe_b_i) |=> boot_rom_select_b_o)
    else $error("select still low after cycle end");
  a_pin_msb_kept:
    assert property (!$past(cfg_wr_i) |-> $stable(pin_assign_o[1]))
    else $error("pin field upper bit changed without write");
  a_port16_pin:
    assert property (port16_o == pin_assign_o[0])
    else $error("port width differs from pin field");
  a_ack_needs_sel:
    assert property (transfer_size_ack_b_o != 2'h3 |-> !boot_rom_select_b_o)
    else $error("acknowledge without select");
  a_ack_lane16:
    assert property (!transfer_size_ack_b_o[1] |-> port16_o && transfer_size_ack_b_o[0])
    else $error("16-bit acknowledge on wrong port");
  a_ack_lane8:
    assert property (!transfer_size_ack_b_o[0] |-> !port16_o && transfer_size_ack_b_o[1])
    else $error("8-bit acknowledge on wrong port");
  // default acknowledge lands exactly 15 cycles after select
  a_wait_thirteen:
    assert property ($fell(boot_rom_select_b_o) && !cfg_seen_q |->
                     ##14 (transfer_size_ack_b_o == 2'h3) ##1 (transfer_size_ack_b_o != 2'h3))
    else $error("default wait count wrong");
  a_base_default:
    assert property (!cfg_seen_q |-> base_o == 13'h0000 && blk_o == 3'h7)
    else $error("base or block size not at reset value");
  a_miss_outside:
    assert property (!cfg_seen_q && addr_i[23:20] != 4'h0 && !addr_strobe_b_i |=> boot_rom_select_b_o)
    else $error("select outside the one megabyte block");

  c_select: cover property ($fell(boot_rom_select_b_o));
  c_ack8: cover property (transfer_size_ack_b_o == 2'h2);
  c_cfg_hit: cover property (cfg_seen_q && $fell(boot_rom_select_b_o));

endmodule

bind bcs_boot_select bcs_boot_select_chk #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk_i            (core_clk_i),
  .rst_b_i               (rst_b_i),
  .addr_i                (addr_i),
  .addr_strobe_b_i       (addr_strobe_b_i),
  .cfg_wr_i              (cfg_wr_i),
  .boot_rom_select_b_o   (boot_rom_select_b_o),
  .transfer_size_ack_b_o (transfer_size_ack_b_o),
  .pin_assign_o          (pin_assign_o),
  .port16_o              (port16_o),
  .base_o                (base_o),
  .blk_o                 (blk_o)
);
`default_nettype wire

//--- bcs_defines.svh
// bcs_defines.svh - reset values, field positions and codes of the boot chip-select block
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH

// boot vector table sits at the bottom of memory
`define BCS_BOOT_VECTOR_ADDR 24'h000000
// base field compares address bits [23:11]
`define BCS_BASE_LSB         11
`define BCS_BASE_W           13
// reset values of the boot base and option fields
`define BCS_RST_BASE         13'h0000
`define BCS_RST_BLK          bcs_pkg::BCS_BLK_1M
`define BCS_RST_SYNC         1'h0
`define BCS_RST_BYTE         bcs_pkg::BCS_BYTE_BOTH
`define BCS_RST_RW           bcs_pkg::BCS_RW_BOTH
`define BCS_RST_STRB         1'h0
`define BCS_RST_ACK          4'hD
`define BCS_RST_SPACE        bcs_pkg::BCS_SP_SUPUSR
`define BCS_RST_IPL          3'h0
`define BCS_RST_AVEC         1'h0
// pin field: upper bit set selects chip-select, lower bit is the pulled-up default
`define BCS_RST_PIN_MSB      1'h1
`define BCS_RST_PIN_LSB      1'h1
// acknowledge field codes: the longest plain wait count, then fast and external
`define BCS_ACK_MAX_WAIT     4'hD
`define BCS_ACK_FAST         4'hE
`define BCS_ACK_EXTERNAL     4'hF
// function code of cpu space
`define BCS_FC_CPU           3'h7
// transfer size code of a single byte
`define BCS_SIZ_BYTE         2'h1

`endif

//--- bcs_pkg.sv
// bcs_pkg.sv - types of the boot chip-select block
package bcs_pkg;

  // block size of the address comparison
  typedef enum logic [2:0] {
    BCS_BLK_2K   = 3'h0,
    BCS_BLK_8K   = 3'h1,
    BCS_BLK_16K  = 3'h2,
    BCS_BLK_64K  = 3'h3,
    BCS_BLK_128K = 3'h4,
    BCS_BLK_256K = 3'h5,
    BCS_BLK_512K = 3'h6,
    BCS_BLK_1M   = 3'h7
  } bcs_blk_t;

  // address space field
  typedef enum logic [1:0] {
    BCS_SP_CPU    = 2'h0,
    BCS_SP_USER   = 2'h1,
    BCS_SP_SUPER  = 2'h2,
    BCS_SP_SUPUSR = 2'h3
  } bcs_space_t;

  // byte lane field
  typedef enum logic [1:0] {
    BCS_BYTE_OFF   = 2'h0,
    BCS_BYTE_LOWER = 2'h1,
    BCS_BYTE_UPPER = 2'h2,
    BCS_BYTE_BOTH  = 2'h3
  } bcs_byte_t;

  // direction field
  typedef enum logic [1:0] {
    BCS_RW_RSVD  = 2'h0,
    BCS_RW_READ  = 2'h1,
    BCS_RW_WRITE = 2'h2,
    BCS_RW_BOTH  = 2'h3
  } bcs_rw_t;

  // internal acknowledge sequencer
  typedef enum logic [1:0] {
    BCS_ST_IDLE = 2'h0,
    BCS_ST_WAIT = 2'h1,
    BCS_ST_ACK  = 2'h2,
    BCS_ST_EXT  = 2'h3
  } bcs_ack_st_t;

endpackage

//--- bcs_rom_model.sv
// bcs_rom_model.sv - far-side boot rom model that straps the port width
`timescale 1ns/1ps
`default_nettype none

module bcs_rom_model (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  // strap level the board wants
  input  wire logic strap_i,
  // strap line towards the device
  output logic      data_line_zero_o
);
  // drive window: through reset and past the first edge after release
  logic [1:0] hold_q;

  //////////////////////////////////////////////////////////////////////////////
  // keep driving one edge past release so the capture edge sees a firm level
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_q <= 2'h3;
    end else begin
      hold_q <= {hold_q[0], 1'b0};
    end
  end

  // active strap drive
  // once released only the weak pull-up is left, so the line reads high
  assign data_line_zero_o = hold_q[1] ? strap_i : 1'b1;

endmodule
`default_nettype wire

//--- bcs_tb.sv
// bcs_tb.sv - self-checking bench of the boot chip-select
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

module testbench;
  // stimulus
  logic        clk, rst_b, strap, dlz, as_b, ds_b, rw, cfg_wr;
  logic [23:0] addr;
  logic [2:0]  fc;
  logic [1:0]  siz, byt, rwf;
  logic [12:0] base;
  logic [3:0]  ack;
  logic [1:0]  pin_f, spc;
  logic        avec;
  // observed
  logic        sel_b, avec_b, p16;
  logic [1:0]  dack_b, pin_o;
  logic [12:0] base_o;
  logic [2:0]  blk_o;
  int          error_cnt, total_checks, cyc_cnt;
  // acknowledge codes swept: zero wait, short, middle, longest, fast, external
  logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h5, 4'hD, 4'hE, 4'hF};

  bcs_boot_select u_dut (
    .core_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .fc_i(fc), .rd_wr_b_i(rw), .siz_i(siz),
    .addr_strobe_b_i(as_b), .data_strb_b_i(ds_b), .eclk_en_i(1'b0), .data_line_zero_i(dlz),
    .cfg_wr_i(cfg_wr), .cfg_pin_i(pin_f), .cfg_base_i(base), .cfg_blk_i(3'h7), .cfg_sync_i(1'b0),
    .cfg_byte_i(byt), .cfg_rw_i(rwf), .cfg_strb_i(1'b0), .cfg_ack_i(ack), .cfg_space_i(spc),
    .cfg_ipl_i(3'h0), .cfg_avec_i(avec), .boot_rom_select_b_o(sel_b), .transfer_size_ack_b_o(dack_b),
    .autovec_b_o(avec_b), .pin_assign_o(pin_o), .port16_o(p16), .base_o(base_o), .blk_o(blk_o));

  bcs_rom_model u_rom (.core_clk_i(clk), .rst_b_i(rst_b), .strap_i(strap), .data_line_zero_o(dlz));

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 4000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // reset with a given strap level, then read back the reset fields
  task automatic do_rst(input logic s);
    rst_b = 1'b0;
    strap = s;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("pin", {1'b1, s}, pin_o)
    `CHK("port16", s, p16)
    `CHK("base", 13'h0000, base_o)
    `CHK("blk", 3'h7, blk_o)
  endtask

  // one bus cycle: es select seen cycle, ea ack cycle (0 = never), el ack lanes
  task automatic cyc(input logic [23:0] a, input logic [2:0] f, input logic r,
                     input int es, input int ea, input logic [1:0] el, input int ev = 0);
    int         sk;
    int         ak;
    int         vk;
    logic [1:0] av;
    sk = 0;
    ak = 0;
    vk = 0;
    av = 2'h3;
    addr = a;
    fc = f;
    rw = r;
    as_b = 1'b0;
    ds_b = 1'b0;
    for (int k = 1; k <= 20; k++) begin
      @(negedge clk);
      if (sk == 0 && sel_b === 1'b0) begin
        sk = k;
      end
      if (ak == 0 && dack_b !== 2'h3) begin
        ak = k;
        av = dack_b;
      end
      // first cycle with the autovector low
      if (vk == 0 && avec_b === 1'b0) begin
        vk = k;
      end
    end
    as_b = 1'b1;
    ds_b = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("select", es, sk)
    `CHK("ack time", ea, ak)
    `CHK("ack lane", el, av)
    `CHK("release", 1'b1, sel_b)
    `CHK("autovec", ev, vk)
  endtask

  // rewrite the option fields in one pulse
  task automatic cfg(input logic [12:0] b, input logic [1:0] rf, input logic [1:0] bf, input logic [3:0] c);
    base = b;
    rwf = rf;
    byt = bf;
    ack = c;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    @(negedge clk);
    `CHK("cfg base", b, base_o)
    `CHK("cfg pin", pin_f, pin_o)
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, strap, as_b, ds_b, rw, cfg_wr} = 6'h1C;
    addr = 24'h000000;
    fc = 3'h6;
    siz = 2'h2;
    base = 13'h0000;
    byt = 2'h3;
    rwf = 2'h3;
    ack = 4'hD;
    pin_f = 2'h3;
    spc = 2'h2;
    avec = 1'b0;
    do_rst(1'b1);
    cyc(24'h000000, 3'h6, 1'b1, 1, 16, 2'h1);
    cyc(24'h0FFFFE, 3'h1, 1'b0, 1, 16, 2'h1);
    cyc(24'h100000, 3'h6, 1'b1, 0, 0, 2'h3);
    cyc(24'h000000, 3'h7, 1'b1, 0, 0, 2'h3);
    do_rst(1'b0);
    cyc(24'h000004, 3'h5, 1'b1, 1, 16, 2'h2);
    foreach (codes[i]) begin
      cfg(13'h0200, 2'h1, 2'h3, codes[i]);
      cyc(24'h100000, 3'h6, 1'b1, 1, codes[i] == 4'hF ? 0 : codes[i] == 4'hE ? 3 : codes[i] + 3,
          codes[i] == 4'hF ? 2'h3 : 2'h1);
    end
    cyc(24'h100000, 3'h6, 1'b0, 0, 0, 2'h3);
    cyc(24'h000000, 3'h6, 1'b1, 0, 0, 2'h3);
    cfg(13'h0200, 2'h3, 2'h0, 4'h0);
    cyc(24'h100000, 3'h6, 1'b1, 0, 0, 2'h3);
    // upper lane only on a 16-bit port: odd address misses
    cfg(13'h0200, 2'h3, 2'h2, 4'h0);
    cyc(24'h100001, 3'h6, 1'b1, 0, 0, 2'h3);
    cyc(24'h100000, 3'h6, 1'b1, 1, 3, 2'h1);
    // user space only: supervisor misses, user hits
    spc = 2'h1;
    cfg(13'h0200, 2'h3, 2'h3, 4'h0);
    cyc(24'h100000, 3'h6, 1'b1, 0, 0, 2'h3);
    cyc(24'h100000, 3'h2, 1'b1, 1, 3, 2'h1);
    // cpu space with internal autovector: ack stays high
    spc = 2'h0;
    avec = 1'b1;
    cfg(13'h0200, 2'h3, 2'h3, 4'h0);
    cyc(24'h100000, 3'h7, 1'b1, 1, 0, 2'h3, 2);
    // pin field upper bit clear turns the select off
    pin_f = 2'h1;
    cfg(13'h0200, 2'h3, 2'h3, 4'h0);
    cyc(24'h100000, 3'h7, 1'b1, 0, 0, 2'h3);
    test_done();
  end

endmodule
`default_nettype wire

//--- bcs_wait_ack.sv
// bcs_wait_ack.sv - wait-state counter that produces the internal transfer acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.svh"

module bcs_wait_ack #(
  parameter int WAIT_W = 4
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  // cycle control
  input  wire logic              select_i,      // boot select asserted
  input  wire logic              cycle_on_i,    // bus cycle in progress
  input  wire logic [WAIT_W-1:0] ack_code_i,    // acknowledge field
  input  wire logic              port16_i,      // 16-bit port
  // acknowledge out
  output logic      [1:0]        ack_b_o        // [1] 16-bit, [0] 8-bit, active low
);

  generate
    if (WAIT_W < 4) begin : g_chk
      $error("bcs_wait_ack: WAIT_W must hold the 4-bit acknowledge field");
    end
  endgenerate

  bcs_pkg::bcs_ack_st_t state_q;  // sequencer state
  logic [WAIT_W-1:0]    cnt_q;    // remaining wait states
  logic [1:0]           ack_q;    // registered acknowledge, active high

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: counts wait states from select assertion to acknowledge
  // internal ack decision
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= bcs_pkg::BCS_ST_IDLE;
      cnt_q   <= '0;
    end else if (!cycle_on_i) begin
      // cycle over: ready for the next one
      state_q <= bcs_pkg::BCS_ST_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        bcs_pkg::BCS_ST_IDLE: begin
          if (select_i) begin
            if (ack_code_i == WAIT_W'(`BCS_ACK_EXTERNAL)) begin
              // the device itself terminates the cycle
              state_q <= bcs_pkg::BCS_ST_EXT;
            end else if (ack_code_i == '0 || ack_code_i == WAIT_W'(`BCS_ACK_FAST)) begin
              state_q <= bcs_pkg::BCS_ST_ACK;
            end else begin
              state_q <= bcs_pkg::BCS_ST_WAIT;
              cnt_q   <= ack_code_i;
            end
          end
        end
        bcs_pkg::BCS_ST_WAIT: begin
          // one wait state per clock
          if (cnt_q == WAIT_W'(1)) begin
            state_q <= bcs_pkg::BCS_ST_ACK;
          end
          cnt_q <= cnt_q - WAIT_W'(1);
        end
        bcs_pkg::BCS_ST_ACK: begin
          state_q <= bcs_pkg::BCS_ST_ACK;
        end
        bcs_pkg::BCS_ST_EXT: begin
          state_q <= bcs_pkg::BCS_ST_EXT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge register: width follows the port size
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= 2'h0;
    end else if (!cycle_on_i) begin
      ack_q <= 2'h0;
    end else if (state_q == bcs_pkg::BCS_ST_ACK) begin
      ack_q <= port16_i ? 2'h2 : 2'h1;
    end
  end

  assign ack_b_o = ~ack_q;

endmodule
`default_nettype wire
